// ===== gas_alarm_delay_config.sv
// Alarm decision, delay selection and configuration of a gas detector.
// Assumes jumpers and gas level arrive asynchronously, a non-volatile store
// that holds the software delay, and a plain register port from software.
`include "gas_alarm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module gas_alarm_delay_config
  import gas_alarm_pkg::*;
#(
  parameter int          TICK_PER_MIN = `CLK_HZ * `SEC_PER_MIN,
  parameter int          FLASH_TICKS  = `CLK_HZ / 1000 * `FLASH_HALF_MS,
  parameter logic [1:0]  VARIANT      = 2'h0,
  parameter logic [11:0] FULL_PPM     = 12'h3E8
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Jumpers, high when fitted.
  input  wire logic        sounder_enable_jumper,
  input  wire logic        halt_jumper,
  input  wire logic        delay_select_bit0,
  input  wire logic        delay_select_bit1,
  // Gas reading and pot setpoint on the 5V scale, 12 bits.
  input  wire logic [11:0] gas_level,
  input  wire logic [11:0] alarm_setpoint_pot,
  // Non-volatile delay store.
  input  wire logic [5:0]  nv_delay,
  output logic             nv_we,
  output logic [5:0]       nv_wdata,
  // Register port.
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // Alarm outputs and analog range select.
  output logic             relay,
  output logic             sounder,
  output logic             red_led,
  output logic             green_led,
  output logic             range_zero_to_five_sel,
  output logic             range_zero_to_ten_sel,
  output logic             range_one_to_five_sel,
  output logic             range_two_to_ten_sel,
  output logic [11:0]      alarm_level_testpoint,
  output logic             irq
);

  // Normalisation length in clock ticks.
  // The product is formed at 36 bits, since a full software delay of an
  // hour at the real clock rate does not fit in 32 bits.
  localparam logic [35:0] NORM_TICKS = 36'(`NORM_MIN) * 36'(TICK_PER_MIN);

  // Default setpoint per variant: 100, 200, 100 or 1500 ppm scaled to 5V.
  function automatic logic [11:0] scale_ppm(input logic [11:0] ppm);
    logic [23:0] p;
    p = 24'(ppm) * 24'hFFF / 24'(FULL_PPM);
    return p[11:0];
  endfunction

  // Synchronised reset and pins.
  logic [1:0]  rst_sync;
  logic        rst_n_i;
  logic [1:0]  s_snd, s_halt, s_d0, s_d1;
  logic [11:0] g1, g2, p1, p2;
  logic [5:0]  nv1, nv2;

  // Two-stage reset release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync[1];

  // Two-flop synchronisers; only the second stage is read.
  // They carry no reset on purpose: they keep sampling while reset is held,
  // so the jumpers and the stored delay are already valid in the first cycle
  // after release, when the boot step reads them once and only once.
  // A reset here would make that boot step see zeros and lose both the
  // stored delay and the jumper override.
  always_ff @(posedge clk) begin
    s_snd  <= {s_snd[0], sounder_enable_jumper};
    s_halt <= {s_halt[0], halt_jumper};
    s_d0   <= {s_d0[0], delay_select_bit0};
    s_d1   <= {s_d1[0], delay_select_bit1};
    g1     <= gas_level;
    g2     <= g1;
    p1     <= alarm_setpoint_pot;
    p2     <= p1;
    nv1    <= nv_delay;
    nv2    <= nv1;
  end

  alarm_state_all_t r_reg, r_next;
  logic [11:0] setpoint;
  logic        over;
  logic        jmp_dly;
  logic [5:0]  dly_min;
  logic [35:0] dly_ticks; // Delay in clock ticks, wide enough for an hour.
  logic [2:0]  ev;
  logic [11:0] dflt_sp;

  // Decision datapath.
  always_comb begin
    case (VARIANT)
      2'h1:    dflt_sp = scale_ppm(12'h0C8);
      2'h2:    dflt_sp = scale_ppm(12'h064);
      2'h3:    dflt_sp = scale_ppm(12'h5DC);
      default: dflt_sp = scale_ppm(12'h064);
    endcase
    // Supervisor setpoint replaces the pot when selected.
    setpoint = r_reg.sp_sel ? r_reg.sw_sp : p2;
    over     = g2 >= setpoint;
    jmp_dly  = s_d0[1] | s_d1[1];
    // Jumper table, else the software value.
    case ({s_d1[1], s_d0[1]})
      2'h1:    dly_min = 6'(`DLY_J1_MIN);
      2'h2:    dly_min = 6'(`DLY_J5_MIN);
      2'h3:    dly_min = 6'(`DLY_J10_MIN);
      default: dly_min = r_reg.sw_dly;
    endcase
    dly_ticks = 36'(dly_min) * 36'(TICK_PER_MIN);
  end

  // Next-state logic for the whole block.
  always_comb begin
    r_next       = r_reg;
    r_next.nv_we = 1'b0;
    ev           = 3'h0;
    r_next.rdata = 16'h0000;
    // Load the stored software delay once, unless a jumper overrides it.
    if (r_reg.boot) begin
      r_next.boot   = 1'b0;
      r_next.sw_dly = jmp_dly ? 6'h00 : nv2;
      if (jmp_dly) begin
        r_next.nv_we    = 1'b1;
        r_next.nv_wdata = 6'h00;
      end
      if (!r_reg.sp_sel) begin
        r_next.sw_sp = dflt_sp;
      end
    end
    // Green flash timer.
    if (r_reg.flash_cnt >= 32'(FLASH_TICKS - 1)) begin
      r_next.flash_cnt = 32'h0;
      r_next.flash     = ~r_reg.flash;
    end else begin
      r_next.flash_cnt = r_reg.flash_cnt + 32'h1;
    end
    case (r_reg.st)
      ST_NORMALISE: begin
        // Warm-up; no detection yet.
        if (r_reg.cnt >= NORM_TICKS - 36'h1) begin
          r_next.st  = ST_IDLE;
          r_next.cnt = 36'h0;
        end else begin
          r_next.cnt = r_reg.cnt + 36'h1;
        end
      end
      ST_IDLE: begin
        if (over) begin
          ev[`EV_ALARM_ON] = 1'b1;
          r_next.cnt = 36'h0;
          r_next.st  = (dly_ticks == 36'h0) ? ST_ACTIVE : ST_PENDING;
          if (dly_ticks == 36'h0) begin
            ev[`EV_OUTPUTS_ON] = 1'b1;
          end
        end
      end
      ST_PENDING: begin
        // A delay cut to zero while pending must end the wait at once;
        // otherwise the end-point subtraction would wrap and never match.
        if (!over) begin
          r_next.st = ST_IDLE;
          ev[`EV_ALARM_OFF] = 1'b1;
        end else if (dly_ticks == 36'h0 ||
                     r_reg.cnt >= dly_ticks - 36'h1) begin
          r_next.st = ST_ACTIVE;
          ev[`EV_OUTPUTS_ON] = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + 36'h1;
        end
      end
      ST_ACTIVE: begin
        if (!over) begin
          r_next.st = ST_IDLE;
          ev[`EV_ALARM_OFF] = 1'b1;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
    // Halt jumper freezes detection and forces outputs quiet.
    if (s_halt[1]) begin
      r_next.st  = ST_IDLE;
      r_next.cnt = 36'h0;
      ev         = 3'h0;
    end
    // Output drive from the next state, registered along with it.
    r_next.o.red_led   = !s_halt[1] && (r_next.st == ST_PENDING ||
                         r_next.st == ST_ACTIVE);
    r_next.o.relay     = !s_halt[1] && r_next.st == ST_ACTIVE;
    r_next.o.sounder   = r_next.o.relay && s_snd[1] &&
                         !r_reg.snd_dis;
    r_next.o.green_led = (r_next.st == ST_NORMALISE) ? r_reg.flash
                         : !s_halt[1];
    // Register writes.
    if (wr) begin
      case (addr)
        `REG_CTRL: begin
          r_next.snd_dis = wdata[`CTRL_SND_DIS];
          r_next.sp_sel  = wdata[`CTRL_SP_SEL];
        end
        `REG_SETPOINT: r_next.sw_sp = wdata[11:0];
        `REG_SW_DELAY: begin
          // Values above the limit are clamped.
          r_next.sw_dly = (wdata[5:0] > 6'(`DLY_SW_MAX_MIN))
                          ? 6'(`DLY_SW_MAX_MIN) : wdata[5:0];
          r_next.nv_we    = !jmp_dly;
          r_next.nv_wdata = r_next.sw_dly;
        end
        `REG_IRQ_STAT: r_next.irq_stat = r_reg.irq_stat & ~wdata[2:0];
        `REG_IRQ_MASK: r_next.irq_mask = wdata[2:0];
        default: ;
      endcase
    end
    // Hardware set wins over a software clear.
    r_next.irq_stat = r_next.irq_stat | ev;
    // Register reads; unmapped reads give zero.
    if (rd) begin
      case (addr)
        `REG_CTRL:     r_next.rdata = {14'h0, r_reg.sp_sel, r_reg.snd_dis};
        `REG_SETPOINT: r_next.rdata = {4'h0, setpoint};
        `REG_SW_DELAY: r_next.rdata = {10'h0, r_reg.sw_dly};
        `REG_STATUS:   r_next.rdata = {8'h0, r_reg.st, s_halt[1], s_snd[1],
                                       r_reg.o};
        `REG_IRQ_STAT: r_next.rdata = {13'h0, r_reg.irq_stat};
        `REG_IRQ_MASK: r_next.rdata = {13'h0, r_reg.irq_mask};
        `REG_CONFIG:   r_next.rdata = {4'h0, dly_min, 4'h0,
                                       s_d1[1], s_d0[1]};
        default:       r_next.rdata = 16'h0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg      <= '0;
      r_reg.st   <= ST_NORMALISE;
      r_reg.boot <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs; the analog range is fixed at its single default.
  assign relay                  = r_reg.o.relay;
  assign sounder                = r_reg.o.sounder;
  assign red_led                = r_reg.o.red_led;
  assign green_led              = r_reg.o.green_led;
  assign rdata                  = r_reg.rdata;
  assign nv_we                  = r_reg.nv_we;
  assign nv_wdata               = r_reg.nv_wdata;
  assign alarm_level_testpoint  = setpoint;
  assign range_zero_to_five_sel = 1'b1;
  assign range_zero_to_ten_sel  = 1'b0;
  assign range_one_to_five_sel  = 1'b0;
  assign range_two_to_ten_sel   = 1'b0;
  assign irq                    = |(r_reg.irq_stat & r_reg.irq_mask);

endmodule

`default_nettype wire

// ===== gas_alarm_defs.svh
// Constants for the gas alarm decision and configuration block.
// Assumes a 10 MHz system clock and a 12-bit gas and setpoint scale.
`ifndef GAS_ALARM_DEFS_SVH
`define GAS_ALARM_DEFS_SVH

// Clock rate in hertz.
`define CLK_HZ          10000000
// Delay figures in minutes.
`define DLY_NONE_MIN    0
`define DLY_J1_MIN      1
`define DLY_J5_MIN      5
`define DLY_J10_MIN     10
`define DLY_SW_MAX_MIN  60
// Normalisation time in minutes.
`define NORM_MIN        5
// Seconds per minute.
`define SEC_PER_MIN     60
// Green LED flash half period in milliseconds.
`define FLASH_HALF_MS   500
// Register offsets.
`define REG_CTRL        4'h0
`define REG_SETPOINT    4'h1
`define REG_SW_DELAY    4'h2
`define REG_STATUS      4'h3
`define REG_IRQ_STAT    4'h4
`define REG_IRQ_MASK    4'h5
`define REG_CONFIG      4'h6
// Control bit positions.
`define CTRL_SND_DIS    0
`define CTRL_SP_SEL     1
// Interrupt event bit positions.
`define EV_ALARM_ON     0
`define EV_ALARM_OFF    1
`define EV_OUTPUTS_ON   2
// Analog range codes.
`define RANGE_0_5       2'h0
`define RANGE_0_10      2'h1
`define RANGE_1_5       2'h2
`define RANGE_2_10      2'h3

`endif

// ===== gas_alarm_pkg.sv
// Types shared by the gas alarm block.
// Assumes the constants header is included by the user of this package.
package gas_alarm_pkg;

  // Alarm decision states.
  typedef enum logic [1:0] {
    ST_NORMALISE,
    ST_IDLE,
    ST_PENDING,
    ST_ACTIVE
  } alarm_state_t;

  // Outputs toward relay, sounder and indicators.
  typedef struct packed {
    logic relay;
    logic sounder;
    logic red_led;
    logic green_led;
  } alarm_out_t;

  // Whole state of the alarm block.
  typedef struct packed {
    alarm_state_t st;
    logic [35:0]  cnt;
    logic [31:0]  flash_cnt;
    logic         flash;
    logic         snd_dis;
    logic         sp_sel;
    logic [11:0]  sw_sp;
    logic [5:0]   sw_dly;
    logic [2:0]   irq_stat;
    logic [2:0]   irq_mask;
    logic [15:0]  rdata;
    alarm_out_t   o;
    logic         nv_we;
    logic [5:0]   nv_wdata;
    logic         boot;
  } alarm_state_all_t;

endpackage

// ===== gas_alarm_assertions.sv
// Checker for the gas alarm block, bound to its top module.
// Assumes the bench shortens one minute to ten clock cycles.
`timescale 1ns/1ps
`default_nettype none
module gas_alarm_checker (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst_n,
  // Jumpers.
  input wire logic       sounder_enable_jumper,
  input wire logic       halt_jumper,
  input wire logic       delay_select_bit0,
  input wire logic       delay_select_bit1,
  // Store and outputs.
  input wire logic       nv_we,
  input wire logic [5:0] nv_wdata,
  input wire logic       relay,
  input wire logic       sounder,
  input wire logic       red_led,
  input wire logic       green_led,
  input wire logic       range_zero_to_five_sel,
  input wire logic       range_zero_to_ten_sel,
  input wire logic       range_one_to_five_sel,
  input wire logic       range_two_to_ten_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Jumpers pass two sync flops, so four stable cycles are allowed.
  property p_snd_jmp; !sounder_enable_jumper [*4] |-> !sounder; endproperty
  property p_snd_relay; sounder |-> relay; endproperty
  property p_halt;
    halt_jumper [*4] |-> !relay && !red_led && !green_led;
  endproperty
  property p_range;
    range_zero_to_five_sel && !range_zero_to_ten_sel &&
      !range_one_to_five_sel && !range_two_to_ten_sel;
  endproperty
  property p_red_first; relay |-> red_led; endproperty
  property p_clear; $fell(red_led) |-> !relay && !sounder; endproperty
  // One minute is ten cycles here, so eight quiet cycles must follow.
  property p_jmp_dly;
    (delay_select_bit0 && !delay_select_bit1) [*4] ##0 $rose(red_led)
      |=> !relay [*8];
  endproperty
  property p_nv_clr;
    (delay_select_bit0 || delay_select_bit1) [*4] ##0 nv_we
      |-> nv_wdata == 6'h00;
  endproperty
  property p_nv_max; nv_we |-> nv_wdata <= 6'h3C; endproperty
  a_snd_jmp: assert property (p_snd_jmp)
    else $error("sounder on with jumper absent");
  a_snd_relay: assert property (p_snd_relay)
    else $error("sounder on without relay");
  a_halt: assert property (p_halt)
    else $error("outputs active while halted");
  a_range: assert property (p_range)
    else $error("range selection not exactly one");
  a_red_first: assert property (p_red_first)
    else $error("relay on without red indicator");
  a_clear: assert property (p_clear)
    else $error("relay or sounder left on after clear");
  a_jmp_dly: assert property (p_jmp_dly)
    else $error("relay before one minute delay");
  a_nv_clr: assert property (p_nv_clr)
    else $error("stored delay not cleared under jumpers");
  a_nv_max: assert property (p_nv_max)
    else $error("stored delay above limit");
  c_relay: cover property ($rose(relay));
  c_muted: cover property (relay && !sounder);
  c_nv: cover property (nv_we);
endmodule
bind gas_alarm_delay_config gas_alarm_checker i_chk (.*);
`default_nettype wire

// ===== nv_store_model.sv
// Model of the non-volatile store that holds the software delay.
// Assumes one write strobe; the value survives the block's reset.
`timescale 1ns/1ps
`default_nettype none
module nv_store_model (
  // Clock.
  input  wire logic       clk,
  // Write side from the block.
  input  wire logic       we,
  input  wire logic [5:0] wdata,
  // Stored value toward the block.
  output logic      [5:0] q
);
  // No reset input, since the store must outlive a power cycle.
  initial q = 6'h00;
  // Written value is kept until the next write.
  always @(posedge clk) begin
    if (we) begin
      q <= wdata;
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the gas alarm block.
// Assumes one minute shortened to ten cycles and the store model beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        sounder_enable_jumper = 1'b1, halt_jumper = 1'b0;
  logic        delay_select_bit0 = 1'b0, delay_select_bit1 = 1'b0;
  logic [11:0] gas_level = 12'h000, alarm_setpoint_pot = 12'h800;
  logic [11:0] alarm_level_testpoint;
  logic [5:0]  nv_delay, nv_wdata;
  logic        nv_we, relay, sounder, red_led, green_led, irq;
  logic        range_zero_to_five_sel, range_zero_to_ten_sel;
  logic        range_one_to_five_sel, range_two_to_ten_sel;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  int          num_errors = 0, n_checks = 0, cyc = 0, n;
  gas_alarm_delay_config #(.TICK_PER_MIN(10), .FLASH_TICKS(2)) i_dut (.*);
  nv_store_model i_nv (.clk(clk), .we(nv_we), .wdata(nv_wdata), .q(nv_delay));
  initial forever #50 clk = ~clk;
  // Cut a hang short well beyond the expected run of about 600 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Raise gas, count cycles from red to relay, then clear the gas.
  task automatic trip(input int dly, input logic snd);
    @(posedge clk);
    gas_level <= 12'hFFF;
    n = 0;
    do begin @(negedge clk); n++; end while (red_led !== 1'b1 && n < 20);
    n = 0;
    while (relay !== 1'b1 && n < 800) begin @(negedge clk); n++; end
    chk(16'(n), 16'(dly * 10));
    chk(16'(sounder), 16'(snd));
    @(posedge clk);
    gas_level <= 12'h000;
    repeat (4) @(negedge clk);
    chk(16'({relay, sounder, red_led}), 16'h0000);
  endtask
  task automatic boot(input int settle);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (settle) @(posedge clk);
  endtask
  initial begin
    boot(0);
    n = 0;
    repeat (40) begin @(negedge clk); n += int'(green_led); end
    chk(16'(n > 10 && n < 30), 16'h0001);
    repeat (30) @(posedge clk);
    rd_reg(4'hF, 16'h0000);
    wr_reg(4'h5, 16'h0001);
    wr_reg(4'h2, 16'h003F);
    rd_reg(4'h2, 16'h003C);
    wr_reg(4'h2, 16'h0003);
    trip(3, 1'b1);
    chk(16'(irq), 16'h0001);
    wr_reg(4'h4, 16'h0007);
    @(negedge clk) chk(16'(irq), 16'h0000);
    boot(70);
    rd_reg(4'h2, 16'h0003);
    wr_reg(4'h2, 16'h0002);
    gas_level <= 12'hFFF;
    repeat (8) @(posedge clk);
    gas_level <= 12'h000;
    repeat (30) begin @(negedge clk); chk(16'(relay), 16'h0000); end
    wr_reg(4'h2, 16'h0000);
    wr_reg(4'h0, 16'h0001);
    trip(0, 1'b0);
    wr_reg(4'h0, 16'h0000);
    sounder_enable_jumper <= 1'b0;
    trip(0, 1'b0);
    sounder_enable_jumper <= 1'b1;
    halt_jumper <= 1'b1;
    gas_level <= 12'hFFF;
    repeat (10) @(negedge clk);
    chk(16'({relay, red_led, green_led}), 16'h0000);
    @(posedge clk);
    gas_level <= 12'h000;
    halt_jumper <= 1'b0;
    wr_reg(4'h0, 16'h0002);
    rd_reg(4'h1, 16'h0199);
    wr_reg(4'h1, 16'h0123);
    rd_reg(4'h1, 16'h0123);
    chk(16'(alarm_level_testpoint), 16'h0123);
    wr_reg(4'h0, 16'h0000);
    @(posedge clk) gas_level <= 12'h7FF;
    repeat (6) @(negedge clk);
    chk(16'(red_led), 16'h0000);
    @(posedge clk) gas_level <= 12'h800;
    repeat (6) @(negedge clk);
    chk(16'(red_led), 16'h0001);
    @(posedge clk) gas_level <= 12'h000;
    wr_reg(4'h2, 16'h0002);
    for (int k = 1; k < 4; k++) begin
      {delay_select_bit1, delay_select_bit0} <= 2'(k);
      repeat (4) @(posedge clk);
      trip(k == 1 ? 1 : (k == 2 ? 5 : 10), 1'b1);
    end
    boot(70);
    chk(16'(nv_delay), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
